// >>> rtl/tmr_pkg.sv
// Constants, register map and mode encodings for the reload/capture/baud timer
// Overview of operation
// - Four byte registers: count low/high and reload/capture low/high, forming 16 bits.
// - Run clear means off; else, with both clock selects clear, capture select picks autoreload or capture.
// - Either serial clock select set with run set gives baud mode.
// - Trigger enable bit 3 decides whether trigger falling edges matter.
// - Autoreload rollover sets overflow flag and loads count from reload pair.
// - Autoreload with trigger enabled: falling trigger edge reloads and sets external flag.
// - Capture mode counts 16 bits; overflow sets flag bit 7, may interrupt.
// - Capture mode with trigger enabled: falling edge copies count into capture bytes.
// - That capture edge sets external flag bit 6, which may interrupt.
// - Baud mode never sets the overflow flag.
// - Baud mode still sets external flag on enabled trigger edges.
// - Run bit starts timer when set, stops it when cleared.
// - Counter select picks external count pin events, else core clock.
// - Clock selects route overflow pulses to serial receive and transmit clocks.
package tmr_pkg;
    // Register indices; printed offsets are not all multiples of four, so byte address = index * 4
    localparam logic [7:0] IDX_CONTROL = 8'hc8;
    localparam logic [7:0] IDX_RELOAD_LOW = 8'hca;
    localparam logic [7:0] IDX_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] IDX_COUNT_LOW = 8'hcc;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'hcd;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hd0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hd1;
    localparam int ADDR_W = 10;
    // Control register fields
    localparam int BIT_CAPTURE_SELECT = 0;
    localparam int BIT_TIMER_COUNTER_SELECT = 1;
    localparam int BIT_RUN_CONTROL = 2;
    localparam int BIT_EXTERNAL_TRIGGER_ENABLE = 3;
    localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
    localparam int BIT_RECEIVE_CLOCK_SELECT = 5;
    localparam int BIT_EXTERNAL_FLAG = 6;
    localparam int BIT_OVERFLOW_FLAG = 7;
    // Interrupt status / mask fields
    localparam int IRQ_OVERFLOW = 0;
    localparam int IRQ_EXTERNAL = 1;
    localparam int IRQ_W = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] MAX_COUNT = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Operating modes, Gray coded
    typedef enum logic [1:0] {
        TMR_OFF = 2'b00,
        TMR_RELOAD = 2'b01,
        TMR_CAPTURE = 2'b11,
        TMR_BAUD = 2'b10
    } tmr_mode_t;
endpackage

// >>> rtl/tmr_fall_det.sv
// Falling edge detector for a synchronous input pin
`timescale 1ns/10ps
module tmr_fall_det (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_pin,
    output logic o_fall
);
    logic prev_q;

    // Previous sample; reset high, so a pin already low at release reads as a falling edge
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= i_pin;
        end
    end

    assign o_fall = prev_q & ~i_pin;
endmodule // tmr_fall_det

// >>> rtl/tmr_timer2.sv
// Sixteen-bit reload/capture/baud timer with AXI4-Lite register slave
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
module tmr_timer2 (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [9:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [9:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_external_count_pin,
    input wire logic i_external_trigger_input,
    output logic o_rx_baud_pulse,
    output logic o_tx_baud_pulse,
    output logic o_rx_clock_from_timer,
    output logic o_tx_clock_from_timer,
    output logic o_irq
);
    logic [7:0] ctrl_q;
    logic [7:0] rcap_lo_q;
    logic [7:0] rcap_hi_q;
    logic [15:0] count_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic aw_held_q;
    logic w_held_q;
    logic [9:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rx_pulse_q;
    logic tx_pulse_q;
    logic trig_fall;
    logic count_fall;
    logic tick;
    logic rollover;
    logic trig_event;
    logic wr_fire;
    logic wr_lane0;
    logic [7:0] wr_byte;
    logic set_ovf;
    logic set_ext;
    tmr_pkg::tmr_mode_t mode;

    // Map a byte address to a register index; a misaligned address gives all ones
    function automatic logic [7:0] reg_index(input logic [9:0] addr);
        if (addr[1:0] != 2'b00) begin
            reg_index = 8'hff;
        end else begin
            reg_index = addr[9:2];
        end
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == tmr_pkg::IDX_CONTROL) || (idx == tmr_pkg::IDX_RELOAD_LOW) ||
                    (idx == tmr_pkg::IDX_RELOAD_HIGH) || (idx == tmr_pkg::IDX_COUNT_LOW) ||
                    (idx == tmr_pkg::IDX_COUNT_HIGH) || (idx == tmr_pkg::IDX_IRQ_STATUS) ||
                    (idx == tmr_pkg::IDX_IRQ_MASK);
    endfunction

    // Edge detectors for trigger and count pins
    tmr_fall_det u_trig_det (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_external_trigger_input),
        .o_fall(trig_fall)
    );
    tmr_fall_det u_count_det (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_external_count_pin),
        .o_fall(count_fall)
    );

    // Mode decode from control bits
    always_comb begin
        if (!ctrl_q[tmr_pkg::BIT_RUN_CONTROL]) begin
            mode = tmr_pkg::TMR_OFF;
        end else if (ctrl_q[tmr_pkg::BIT_RECEIVE_CLOCK_SELECT] || ctrl_q[tmr_pkg::BIT_TRANSMIT_CLOCK_SELECT]) begin
            mode = tmr_pkg::TMR_BAUD;
        end else if (ctrl_q[tmr_pkg::BIT_CAPTURE_SELECT]) begin
            mode = tmr_pkg::TMR_CAPTURE;
        end else begin
            mode = tmr_pkg::TMR_RELOAD;
        end
    end

    // Count source: core clock every cycle, or pin falling edges
    assign tick = (mode != tmr_pkg::TMR_OFF) &&
                  (ctrl_q[tmr_pkg::BIT_TIMER_COUNTER_SELECT] ? count_fall : 1'b1);
    assign rollover = tick && (count_q == tmr_pkg::MAX_COUNT);
    assign trig_event = trig_fall && ctrl_q[tmr_pkg::BIT_EXTERNAL_TRIGGER_ENABLE];
    assign set_ovf = rollover && (mode != tmr_pkg::TMR_BAUD);
    assign set_ext = trig_event && (mode != tmr_pkg::TMR_OFF);

    // Bus write commits when both address and data are held and response slot is free
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_lane0 = wr_fire && wstrb_q[0] && is_mapped(reg_index(awaddr_q));
    assign wr_byte = wdata_q[7:0];

    // Write address channel capture
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end else if (i_awvalid && o_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= i_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    // Write data channel capture, independent of address order
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (i_wvalid && o_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    assign o_awready = !aw_held_q;
    assign o_wready = !w_held_q;

    // Write response
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= tmr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(reg_index(awaddr_q)) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
        end else if (i_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;

    // Control register; hardware flag set wins over a software write of zero
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= tmr_pkg::RST_BYTE;
        end else begin
            if (wr_lane0 && reg_index(awaddr_q) == tmr_pkg::IDX_CONTROL) begin
                ctrl_q <= wr_byte;
            end
            if (set_ovf) begin
                ctrl_q[tmr_pkg::BIT_OVERFLOW_FLAG] <= 1'b1;
            end
            if (set_ext) begin
                ctrl_q[tmr_pkg::BIT_EXTERNAL_FLAG] <= 1'b1;
            end
        end
    end

    // Counter: reload on rollover/trigger in reload mode, on rollover only in baud mode; software write otherwise
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= {tmr_pkg::RST_BYTE, tmr_pkg::RST_BYTE};
        end else if ((mode == tmr_pkg::TMR_RELOAD && (rollover || trig_event)) ||
                     (mode == tmr_pkg::TMR_BAUD && rollover)) begin
            count_q <= {rcap_hi_q, rcap_lo_q};
        end else if (wr_lane0 && reg_index(awaddr_q) == tmr_pkg::IDX_COUNT_LOW) begin
            count_q[7:0] <= wr_byte;
        end else if (wr_lane0 && reg_index(awaddr_q) == tmr_pkg::IDX_COUNT_HIGH) begin
            count_q[15:8] <= wr_byte;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // Reload/capture pair; a capture edge takes priority over a software write
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rcap_lo_q <= tmr_pkg::RST_BYTE;
            rcap_hi_q <= tmr_pkg::RST_BYTE;
        end else if (mode == tmr_pkg::TMR_CAPTURE && trig_event) begin
            rcap_lo_q <= count_q[7:0];
            rcap_hi_q <= count_q[15:8];
        end else if (wr_lane0 && reg_index(awaddr_q) == tmr_pkg::IDX_RELOAD_LOW) begin
            rcap_lo_q <= wr_byte;
        end else if (wr_lane0 && reg_index(awaddr_q) == tmr_pkg::IDX_RELOAD_HIGH) begin
            rcap_hi_q <= wr_byte;
        end
    end

    // Sticky interrupt status, write one to clear; new event wins over clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            if (wr_lane0 && reg_index(awaddr_q) == tmr_pkg::IDX_IRQ_MASK) begin
                irq_mask_q <= wr_byte[tmr_pkg::IRQ_W-1:0];
            end
            irq_stat_q <= (irq_stat_q & ~((wr_lane0 && reg_index(awaddr_q) == tmr_pkg::IDX_IRQ_STATUS) ?
                          wr_byte[tmr_pkg::IRQ_W-1:0] : 2'b00)) | {set_ext, set_ovf};
        end
    end

    assign o_irq = |(irq_stat_q & irq_mask_q);

    // Baud pulses to the serial port, one cycle per rollover
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_pulse_q <= 1'b0;
            tx_pulse_q <= 1'b0;
        end else begin
            rx_pulse_q <= rollover && ctrl_q[tmr_pkg::BIT_RECEIVE_CLOCK_SELECT];
            tx_pulse_q <= rollover && ctrl_q[tmr_pkg::BIT_TRANSMIT_CLOCK_SELECT];
        end
    end

    assign o_rx_baud_pulse = rx_pulse_q;
    assign o_tx_baud_pulse = tx_pulse_q;
    assign o_rx_clock_from_timer = ctrl_q[tmr_pkg::BIT_RECEIVE_CLOCK_SELECT];
    assign o_tx_clock_from_timer = ctrl_q[tmr_pkg::BIT_TRANSMIT_CLOCK_SELECT];

    // Read channel: one-cycle registered answer, held until rready
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= tmr_pkg::RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(reg_index(i_araddr)) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
            case (reg_index(i_araddr))
                tmr_pkg::IDX_CONTROL: rdata_q <= {24'h000000, ctrl_q};
                tmr_pkg::IDX_RELOAD_LOW: rdata_q <= {24'h000000, rcap_lo_q};
                tmr_pkg::IDX_RELOAD_HIGH: rdata_q <= {24'h000000, rcap_hi_q};
                tmr_pkg::IDX_COUNT_LOW: rdata_q <= {24'h000000, count_q[7:0]};
                tmr_pkg::IDX_COUNT_HIGH: rdata_q <= {24'h000000, count_q[15:8]};
                tmr_pkg::IDX_IRQ_STATUS: rdata_q <= {30'h0, irq_stat_q};
                tmr_pkg::IDX_IRQ_MASK: rdata_q <= {30'h0, irq_mask_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end else if (i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign o_arready = !rvalid_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;

    // Checks
    property p_ovf_sets;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        set_ovf |=> ctrl_q[tmr_pkg::BIT_OVERFLOW_FLAG];
    endproperty
    a_ovf_sets: assert property (p_ovf_sets) else $error("overflow flag not set");

    property p_baud_no_ovf;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode == tmr_pkg::TMR_BAUD && !ctrl_q[tmr_pkg::BIT_OVERFLOW_FLAG] && !wr_fire)
        |=> !ctrl_q[tmr_pkg::BIT_OVERFLOW_FLAG];
    endproperty
    a_baud_no_ovf: assert property (p_baud_no_ovf) else $error("overflow flag set in baud mode");

    // Count took the reload pair that stood one cycle earlier
    sequence s_reloaded;
        count_q == $past({rcap_hi_q, rcap_lo_q});
    endsequence

    property p_reload;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode == tmr_pkg::TMR_RELOAD && rollover) |=> s_reloaded;
    endproperty
    a_reload: assert property (p_reload) else $error("reload value wrong");

    property p_trig_reload;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode == tmr_pkg::TMR_RELOAD && trig_event) |=> count_q == $past({rcap_hi_q, rcap_lo_q})
        && ctrl_q[tmr_pkg::BIT_EXTERNAL_FLAG];
    endproperty
    a_trig_reload: assert property (p_trig_reload) else $error("trigger reload failed");

    property p_capture;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode == tmr_pkg::TMR_CAPTURE && trig_event) |=> {rcap_hi_q, rcap_lo_q} == $past(count_q);
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong");

    property p_off_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode == tmr_pkg::TMR_OFF && !wr_fire) |=> count_q == $past(count_q);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("counter moved while stopped");

    property p_ext_gate;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (trig_fall && !ctrl_q[tmr_pkg::BIT_EXTERNAL_TRIGGER_ENABLE]) |-> !set_ext;
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("trigger edge acted while disabled");

    property p_baud_ext;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode == tmr_pkg::TMR_BAUD && trig_event) |=> ctrl_q[tmr_pkg::BIT_EXTERNAL_FLAG] && irq_stat_q[1];
    endproperty
    a_baud_ext: assert property (p_baud_ext) else $error("external flag missing in baud mode");

    property p_baud_pulse;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (rollover && ctrl_q[tmr_pkg::BIT_TRANSMIT_CLOCK_SELECT]) |=> o_tx_baud_pulse;
    endproperty
    a_baud_pulse: assert property (p_baud_pulse) else $error("transmit baud pulse missing");
endmodule // tmr_timer2

// >>> verif/tmr_pin_model.sv
// Far-side model: external count and trigger pins, serial port pulse consumer
`timescale 1ns/10ps
module tmr_pin_model (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_rx_baud_pulse,
    input wire logic i_tx_baud_pulse,
    output logic o_count_pin,
    output logic o_trigger_pin,
    output logic [15:0] o_rx_pulses,
    output logic [15:0] o_tx_pulses
);
    // Pins idle high, so only a deliberate low phase makes an edge
    initial o_count_pin = 1'b1;
    initial o_trigger_pin = 1'b1;
    // Serial side counts every overflow pulse it is handed
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_pulses <= 16'h0000;
            o_tx_pulses <= 16'h0000;
        end else begin
            o_rx_pulses <= o_rx_pulses + {15'h0, i_rx_baud_pulse};
            o_tx_pulses <= o_tx_pulses + {15'h0, i_tx_baud_pulse};
        end
    end
    // Low phase of three cycles, long enough for a clocked sample compare
    task automatic fire_trigger();
        @(posedge i_ref_clk);
        o_trigger_pin <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        o_trigger_pin <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
    endtask
    // One falling edge per event, two cycles low and three high
    task automatic pulse_count(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge i_ref_clk);
            o_count_pin <= 1'b0;
            repeat (2) @(posedge i_ref_clk);
            o_count_pin <= 1'b1;
            repeat (2) @(posedge i_ref_clk);
        end
        repeat (3) @(posedge i_ref_clk);
    endtask
endmodule // tmr_pin_model

// >>> verif/test_tmr_timer2.sv
// Self-checking bench for the reload/capture/baud timer
`timescale 1ns/10ps
module test_tmr_timer2;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [9:0] awaddr = 10'h000;
    logic [9:0] araddr = 10'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, cnt_pin, trig_pin;
    logic rx_pulse, tx_pulse, rx_sel, tx_sel;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata;
    logic [7:0] rd_q, tmp;
    logic [15:0] rx_n, tx_n, rx_base, tx_base;
    logic [7:0] regs [5] = '{tmr_pkg::IDX_CONTROL, tmr_pkg::IDX_RELOAD_LOW, tmr_pkg::IDX_RELOAD_HIGH,
        tmr_pkg::IDX_COUNT_LOW, tmr_pkg::IDX_COUNT_HIGH};
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    // Free-running 125 MHz clock
    always #4 i_ref_clk = ~i_ref_clk;
    tmr_timer2 i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_external_count_pin(cnt_pin), .i_external_trigger_input(trig_pin), .o_rx_baud_pulse(rx_pulse),
        .o_tx_baud_pulse(tx_pulse), .o_rx_clock_from_timer(rx_sel), .o_tx_clock_from_timer(tx_sel),
        .o_irq(irq));
    tmr_pin_model i_model (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_rx_baud_pulse(rx_pulse),
        .i_tx_baud_pulse(tx_pulse), .o_count_pin(cnt_pin), .o_trigger_pin(trig_pin), .o_rx_pulses(rx_n),
        .o_tx_pulses(tx_n));
    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge i_ref_clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx);
        @(posedge i_ref_clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_q = rdata[7:0];
        rsp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        rd(idx);
        chk8(rd_q, exp);
    endtask
    task automatic load(input logic [7:0] lo_idx, input logic [15:0] v);
        wr(lo_idx, v[7:0]);
        wr(lo_idx + 8'h01, v[15:8]);
    endtask
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        foreach (regs[i]) rdchk(regs[i], tmr_pkg::RST_BYTE);
        chk8({6'h0, rsp}, {6'h0, tmr_pkg::RESP_OKAY});
        rd(8'hff);
        chk8({6'h0, rsp}, {6'h0, tmr_pkg::RESP_SLVERR});
        chk8(rd_q, 8'h00);
        wr(8'hff, 8'h5a);
        chk8({6'h0, rsp}, {6'h0, tmr_pkg::RESP_SLVERR});
        // Autoreload rollover, overflow interrupt, stop
        load(tmr_pkg::IDX_RELOAD_LOW, 16'hfff0);
        chk8({6'h0, rsp}, {6'h0, tmr_pkg::RESP_OKAY});
        load(tmr_pkg::IDX_COUNT_LOW, 16'hfff0);
        wr(tmr_pkg::IDX_IRQ_MASK, 8'h01);
        wr(tmr_pkg::IDX_CONTROL, 8'h04);
        repeat (40) @(posedge i_ref_clk);
        rd(tmr_pkg::IDX_CONTROL);
        chk1(rd_q[tmr_pkg::BIT_OVERFLOW_FLAG], 1'b1);
        chk1(irq, 1'b1);
        rdchk(tmr_pkg::IDX_COUNT_HIGH, 8'hff);
        wr(tmr_pkg::IDX_CONTROL, 8'h00);
        rd(tmr_pkg::IDX_COUNT_LOW);
        tmp = rd_q;
        repeat (10) @(posedge i_ref_clk);
        rdchk(tmr_pkg::IDX_COUNT_LOW, tmp);
        wr(tmr_pkg::IDX_IRQ_STATUS, 8'h01);
        chk1(irq, 1'b0);
        // Trigger ignored, then honoured, in autoreload
        load(tmr_pkg::IDX_RELOAD_LOW, 16'h5555);
        load(tmr_pkg::IDX_COUNT_LOW, 16'h1234);
        wr(tmr_pkg::IDX_CONTROL, 8'h04);
        i_model.fire_trigger();
        rd(tmr_pkg::IDX_CONTROL);
        chk1(rd_q[tmr_pkg::BIT_EXTERNAL_FLAG], 1'b0);
        rdchk(tmr_pkg::IDX_COUNT_HIGH, 8'h12);
        wr(tmr_pkg::IDX_CONTROL, 8'h0c);
        i_model.fire_trigger();
        rd(tmr_pkg::IDX_CONTROL);
        chk1(rd_q[tmr_pkg::BIT_EXTERNAL_FLAG], 1'b1);
        rdchk(tmr_pkg::IDX_COUNT_HIGH, 8'h55);
        chk1(irq, 1'b0);
        wr(tmr_pkg::IDX_IRQ_MASK, 8'h03);
        chk1(irq, 1'b1);
        wr(tmr_pkg::IDX_IRQ_STATUS, 8'h03);
        wr(tmr_pkg::IDX_IRQ_MASK, 8'h00);
        // Capture on trigger, then overflow wraps to zero
        wr(tmr_pkg::IDX_CONTROL, 8'h00);
        load(tmr_pkg::IDX_COUNT_LOW, 16'h2200);
        wr(tmr_pkg::IDX_CONTROL, 8'h0d);
        i_model.fire_trigger();
        rdchk(tmr_pkg::IDX_RELOAD_HIGH, 8'h22);
        rd(tmr_pkg::IDX_CONTROL);
        chk1(rd_q[tmr_pkg::BIT_EXTERNAL_FLAG], 1'b1);
        wr(tmr_pkg::IDX_CONTROL, 8'h00);
        load(tmr_pkg::IDX_COUNT_LOW, 16'hfff0);
        wr(tmr_pkg::IDX_CONTROL, 8'h05);
        repeat (40) @(posedge i_ref_clk);
        rd(tmr_pkg::IDX_CONTROL);
        chk1(rd_q[tmr_pkg::BIT_OVERFLOW_FLAG], 1'b1);
        rdchk(tmr_pkg::IDX_COUNT_HIGH, 8'h00);
        // Baud mode with capture select set: reloads, pulses, no overflow flag
        wr(tmr_pkg::IDX_CONTROL, 8'h00);
        load(tmr_pkg::IDX_RELOAD_LOW, 16'hfff8);
        load(tmr_pkg::IDX_COUNT_LOW, 16'hfff8);
        rx_base = rx_n;
        tx_base = tx_n;
        wr(tmr_pkg::IDX_CONTROL, 8'h3d);
        repeat (80) @(posedge i_ref_clk);
        chk1((tx_n - tx_base) >= 16'h0008, 1'b1);
        chk1((rx_n - rx_base) >= 16'h0008, 1'b1);
        chk1(tx_sel & rx_sel, 1'b1);
        rdchk(tmr_pkg::IDX_COUNT_HIGH, 8'hff);
        rd(tmr_pkg::IDX_CONTROL);
        chk1(rd_q[tmr_pkg::BIT_OVERFLOW_FLAG], 1'b0);
        i_model.fire_trigger();
        rd(tmr_pkg::IDX_CONTROL);
        chk1(rd_q[tmr_pkg::BIT_EXTERNAL_FLAG], 1'b1);
        // Counter function counts pin edges only
        wr(tmr_pkg::IDX_CONTROL, 8'h00);
        load(tmr_pkg::IDX_COUNT_LOW, 16'h0000);
        wr(tmr_pkg::IDX_CONTROL, 8'h06);
        repeat (20) @(posedge i_ref_clk);
        rdchk(tmr_pkg::IDX_COUNT_LOW, 8'h00);
        i_model.pulse_count(5);
        rdchk(tmr_pkg::IDX_COUNT_LOW, 8'h05);
        final_report();
    end
endmodule // test_tmr_timer2
